// ==== core/ewt_defs.svh ====
`ifndef EWT_DEFS_SVH
`define EWT_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets on the apb window
// ---------------------------------------------------------------
`define EWT_OFF_SDW   12'h000
`define EWT_OFF_PC5   12'h004
`define EWT_OFF_PC6   12'h008
`define EWT_OFF_STAT  12'h00C

// ---------------------------------------------------------------
// sdram area 3 wait control fields
// ---------------------------------------------------------------
`define EWT_TRC_LSB   0
`define EWT_TRWL_LSB  3
`define EWT_CAS_LSB   7
`define EWT_TRCD_LSB  10
`define EWT_TRP_LSB   13
`define EWT_SDW_RST   32'h00000500
`define EWT_SDW_MASK  32'h00006D9B

// ---------------------------------------------------------------
// pc card area wait control fields
// ---------------------------------------------------------------
`define EWT_TEH_LSB   0
`define EWT_WM_BIT    6
`define EWT_PCW_LSB   7
`define EWT_TED_LSB   11
`define EWT_SA_LO_BIT 20
`define EWT_SA_HI_BIT 21
`define EWT_PC_RST    32'h00000500
`define EWT_PC_MASK   32'h00307FCF

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define EWT_ST_GAP_BIT  0
`define EWT_ST_ACT_LSB  1
`define EWT_ST_PRE_LSB  5
`define EWT_ST_PCB_BIT  9
`define EWT_ST_VIOL_BIT 16

// ---------------------------------------------------------------
// refresh gap idle cycles per code
// ---------------------------------------------------------------
`define EWT_GAP_C0    4'h2
`define EWT_GAP_C1    4'h3
`define EWT_GAP_C2    4'h5
`define EWT_GAP_C3    4'h8

`endif

// ==== core/ewt_pkg.sv ====
package ewt_pkg;

  // command presented by the sdram sequencer
  typedef enum logic [2:0] {
    EWT_CMD_NOP,
    EWT_CMD_ACTV,
    EWT_CMD_REF,
    EWT_CMD_MRS,
    EWT_CMD_WRITA,
    EWT_CMD_WRIT,
    EWT_CMD_PRE,
    EWT_CMD_READ
  } ewt_sd_cmd_t;

  // pc card strobe sequencer states
  typedef enum logic [1:0] {
    EWT_STB_IDLE,
    EWT_STB_DELAY,
    EWT_STB_ON
  } ewt_stb_state_t;

endpackage

// ==== core/ewt_wait_cnt.sv ====
`timescale 1ns/1ps

module ewt_wait_cnt #(
  parameter int W = 4
) (
  input  wire logic         clk_in,  // bus clock
  input  wire logic         rst_in,  // sync reset, high
  input  wire logic         load_in, // restart the wait
  input  wire logic [W-1:0] val_in,  // idle cycles to wait
  output logic              ok_out   // wait elapsed
);

  if (W < 1) begin : g_bad_w
    $error("ewt_wait_cnt: W must be at least 1");
  end

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         ok_q;
  logic         ok_d;

  // a new load restarts the count, so the later command always wins
  always_comb begin
    if (load_in) begin
      cnt_d = val_in;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end else begin
      cnt_d = cnt_q;
    end
    ok_d = (cnt_d == '0);
  end

  // register count and flag together so they never disagree
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      ok_q  <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      ok_q  <= ok_d;
    end
  end

  assign ok_out = ok_q;

endmodule // ewt_wait_cnt

// ==== core/ewt_pc_strobe.sv ====
`timescale 1ns/1ps

module ewt_pc_strobe (
  input  wire logic       clk_in,   // bus clock
  input  wire logic       rst_in,   // sync reset, high
  input  wire logic       start_in, // address driven this edge
  input  wire logic       end_in,   // access finished
  input  wire logic       write_in, // direction of access
  input  wire logic [3:0] ted_in,   // address to strobe code
  output logic            rd_out,   // read strobe asserted
  output logic            we_out,   // write strobe asserted
  output logic            busy_out  // access in progress
);

  ewt_pkg::ewt_stb_state_t st_q;
  ewt_pkg::ewt_stb_state_t st_d;
  logic [3:0]              cnt_q;
  logic [3:0]              cnt_d;
  logic                    wr_q;
  logic                    wr_d;
  logic                    rd_n_q;
  logic                    we_n_q;

  // whole cycles counted on the rising edge, strobe armed at the last
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    wr_d  = wr_q;
    case (st_q)
      ewt_pkg::EWT_STB_IDLE: begin
        if (start_in) begin
          wr_d  = write_in;
          cnt_d = ted_in;
          st_d  = (ted_in == 4'h0) ? ewt_pkg::EWT_STB_ON : ewt_pkg::EWT_STB_DELAY;
        end
      end
      ewt_pkg::EWT_STB_DELAY: begin
        cnt_d = cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          st_d = ewt_pkg::EWT_STB_ON;
        end
        if (end_in) begin
          st_d = ewt_pkg::EWT_STB_IDLE;
        end
      end
      ewt_pkg::EWT_STB_ON: begin
        if (end_in) begin
          st_d = ewt_pkg::EWT_STB_IDLE;
        end
      end
      default: st_d = ewt_pkg::EWT_STB_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q  <= ewt_pkg::EWT_STB_IDLE;
      cnt_q <= 4'h0;
      wr_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      wr_q  <= wr_d;
    end
  end

  // falling edge launch adds the half cycle after the address edge
  always_ff @(negedge clk_in) begin
    if (rst_in) begin
      rd_n_q <= 1'b0;
      we_n_q <= 1'b0;
    end else begin
      rd_n_q <= (st_q == ewt_pkg::EWT_STB_ON) && !wr_q;
      we_n_q <= (st_q == ewt_pkg::EWT_STB_ON) && wr_q;
    end
  end

  assign rd_out   = rd_n_q;
  assign we_out   = we_n_q;
  assign busy_out = (st_q != ewt_pkg::EWT_STB_IDLE);

endmodule // ewt_pc_strobe

// ==== core/ewt_top.sv ====
// How it works
// - precharge-start code 0..3 gives a wait of 0..3 cycles
// - non-bank-active: after write-autoprecharge, activate to that bank waits that time
// - bank-active: write then other-row access waits that time before precharge
// - refresh-gap code 0..3 gives 2, 3, 5 or 8 idle cycles
// - after refresh, activate, refresh and mode-set wait the refresh gap
// - after self-refresh release, the same commands wait the refresh gap
// - areas 2 and 3 share one set of sdram timing settings
// - top address high: upper attribute bit picks memory or io card
// - top address low: lower attribute bit picks memory or io card
// - strobe follows address by delay code plus half a cycle
// - reserved bits read zero and software writes them as zero
`timescale 1ns/1ps
`include "ewt_defs.svh"

module ewt_top #(
  parameter int NUM_BANKS = 4
) (
  input  wire logic                     CLOCK_IN,         // bus clock, 250 MHz
  input  wire logic                     RST_IN,           // sync reset, high
  // apb slave
  input  wire logic                     PSEL_IN,          // apb select
  input  wire logic                     PENABLE_IN,       // apb access phase
  input  wire logic                     PWRITE_IN,        // apb write
  input  wire logic [11:0]              PADDR_IN,         // apb byte address
  input  wire logic [31:0]              PWDATA_IN,        // apb write data
  input  wire logic [3:0]               PSTRB_IN,         // apb byte strobes
  output logic      [31:0]              PRDATA_OUT,       // apb read data
  output logic                          PREADY_OUT,       // apb ready
  output logic                          PSLVERR_OUT,      // apb error
  // sdram sequencer side
  input  wire logic                     SD_CMD_VALID_IN,  // command issued now
  input  wire ewt_pkg::ewt_sd_cmd_t     SD_CMD_IN,        // command code
  input  wire logic [$clog2(NUM_BANKS)-1:0] SD_BANK_IN,   // target bank
  input  wire logic                     SD_SELF_EXIT_IN,  // self refresh released
  input  wire logic                     SD_BANK_ACT_IN,   // bank-active mode
  output logic      [NUM_BANKS-1:0]     SD_ACTV_OK_OUT,   // activate allowed per bank
  output logic      [NUM_BANKS-1:0]     SD_PRE_OK_OUT,    // precharge allowed per bank
  output logic                          SD_GAP_OK_OUT,    // refresh gap elapsed
  output logic      [1:0]               SD_TRP_OUT,       // precharge done wait
  output logic      [1:0]               SD_TRCD_OUT,      // row to column wait
  output logic      [1:0]               SD_CAS3_OUT,      // area 3 cas latency code
  // pc card side
  input  wire logic                     PC_START_IN,      // address driven now
  input  wire logic                     PC_AREA_IN,       // 0 area 5, 1 area 6
  input  wire logic                     PC_A25_IN,        // top address line
  input  wire logic                     PC_WRITE_IN,      // access direction
  input  wire logic                     PC_END_IN,        // access finished
  output logic                          PC_IO_CARD_OUT,   // 1 io card, 0 memory card
  output logic                          PC_RD_ASSERT_OUT, // read strobe asserted
  output logic                          PC_WE_ASSERT_OUT  // write strobe asserted
);

  localparam int BW = $clog2(NUM_BANKS);

  if (NUM_BANKS < 2 || NUM_BANKS > 4 || (NUM_BANKS & (NUM_BANKS - 1)) != 0) begin : g_bad_banks
    $error("ewt_top: NUM_BANKS must be 2 or 4");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0]          sdw_q;
  logic [31:0]          sdw_d;
  logic [31:0]          pc5_q;
  logic [31:0]          pc5_d;
  logic [31:0]          pc6_q;
  logic [31:0]          pc6_d;
  logic                 viol_q;
  logic                 viol_d;
  logic [31:0]          prdata_q;
  logic [31:0]          prdata_d;
  logic                 pready_q;
  logic                 pready_d;
  logic                 pslverr_q;
  logic                 pslverr_d;
  logic                 io_card_q;
  logic                 io_card_d;
  logic [31:0]          rd_mux;
  logic                 hit;
  logic                 first;
  logic                 commit;
  logic [31:0]          stat;
  logic [3:0]           gap_val;
  logic                 gap_load;
  logic                 gap_ok;
  logic [NUM_BANKS-1:0] act_ok;
  logic [NUM_BANKS-1:0] pre_ok;
  logic                 blocked;
  logic                 stb_busy;
  logic [31:0]          pc_sel;
  logic [3:0]           ted;

  // ---------------------------------------------------------------
  // register write helper
  // ---------------------------------------------------------------
  // byte strobes merge lanes; the mask keeps reserved flops at zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  // ready is registered, so every access phase takes two cycles
  assign first  = PSEL_IN && PENABLE_IN && !pready_q;
  assign commit = PSEL_IN && PENABLE_IN && pready_q;

  // live status view; hold bits are the inverse of the ready flags
  always_comb begin
    stat = 32'h00000000;
    stat[`EWT_ST_GAP_BIT] = !gap_ok;
    stat[`EWT_ST_ACT_LSB +: NUM_BANKS] = ~act_ok;
    stat[`EWT_ST_PRE_LSB +: NUM_BANKS] = ~pre_ok;
    stat[`EWT_ST_PCB_BIT] = stb_busy;
    stat[`EWT_ST_VIOL_BIT] = viol_q;
  end

  // read decode; anything else, unaligned included, is an error
  always_comb begin
    rd_mux = 32'h00000000;
    hit    = 1'b1;
    case (PADDR_IN)
      `EWT_OFF_SDW:  rd_mux = sdw_q;
      `EWT_OFF_PC5:  rd_mux = pc5_q;
      `EWT_OFF_PC6:  rd_mux = pc6_q;
      `EWT_OFF_STAT: rd_mux = stat;
      default:       hit    = 1'b0;
    endcase
  end

  // answer is prepared at the first access edge; ready and error last one cycle, read data holds until the next access
  always_comb begin
    pready_d  = first;
    pslverr_d = first && !hit;
    prdata_d  = prdata_q;
    if (first) begin
      prdata_d = (PWRITE_IN || !hit) ? 32'h00000000 : rd_mux;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // writes land only at the edge where ready is seen high
  always_comb begin
    sdw_d = sdw_q;
    pc5_d = pc5_q;
    pc6_d = pc6_q;
    if (commit && PWRITE_IN) begin
      case (PADDR_IN)
        `EWT_OFF_SDW: sdw_d = merge(sdw_q, PWDATA_IN, PSTRB_IN, `EWT_SDW_MASK);
        `EWT_OFF_PC5: pc5_d = merge(pc5_q, PWDATA_IN, PSTRB_IN, `EWT_PC_MASK);
        `EWT_OFF_PC6: pc6_d = merge(pc6_q, PWDATA_IN, PSTRB_IN, `EWT_PC_MASK);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      sdw_q <= `EWT_SDW_RST;
      pc5_q <= `EWT_PC_RST;
      pc6_q <= `EWT_PC_RST;
    end else begin
      sdw_q <= sdw_d;
      pc5_q <= pc5_d;
      pc6_q <= pc6_d;
    end
  end

  // ---------------------------------------------------------------
  // sdram refresh gap
  // ---------------------------------------------------------------
  // one field serves both sdram areas, nothing is kept per area
  always_comb begin
    case (sdw_q[`EWT_TRC_LSB +: 2])
      2'b00:   gap_val = `EWT_GAP_C0;
      2'b01:   gap_val = `EWT_GAP_C1;
      2'b10:   gap_val = `EWT_GAP_C2;
      default: gap_val = `EWT_GAP_C3;
    endcase
  end

  // refresh and self refresh release both start the idle gap
  assign gap_load = (SD_CMD_VALID_IN && SD_CMD_IN == ewt_pkg::EWT_CMD_REF)
                 || SD_SELF_EXIT_IN;

  ewt_wait_cnt #(
    .W (4)
  ) u_gap (
    .clk_in  (CLOCK_IN),
    .rst_in  (RST_IN),
    .load_in (gap_load),
    .val_in  (gap_val),
    .ok_out  (gap_ok)
  );

  // ---------------------------------------------------------------
  // sdram precharge start wait per bank
  // ---------------------------------------------------------------
  // the code is the cycle count itself, so it feeds the counters raw
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic act_load;
    logic pre_load;

    // write with auto precharge holds off a later activate
    assign act_load = SD_CMD_VALID_IN && !SD_BANK_ACT_IN && SD_BANK_IN == BW'(b)
                   && SD_CMD_IN == ewt_pkg::EWT_CMD_WRITA;
    // a plain write in bank-active mode holds off the precharge
    assign pre_load = SD_CMD_VALID_IN && SD_BANK_ACT_IN && SD_BANK_IN == BW'(b)
                   && SD_CMD_IN == ewt_pkg::EWT_CMD_WRIT;

    ewt_wait_cnt #(
      .W (2)
    ) u_act (
      .clk_in  (CLOCK_IN),
      .rst_in  (RST_IN),
      .load_in (act_load),
      .val_in  (sdw_q[`EWT_TRWL_LSB +: 2]),
      .ok_out  (act_ok[b])
    );

    ewt_wait_cnt #(
      .W (2)
    ) u_pre (
      .clk_in  (CLOCK_IN),
      .rst_in  (RST_IN),
      .load_in (pre_load),
      .val_in  (sdw_q[`EWT_TRWL_LSB +: 2]),
      .ok_out  (pre_ok[b])
    );
  end

  // ---------------------------------------------------------------
  // sequencer misuse flag
  // ---------------------------------------------------------------
  // catches a sequencer that ignores the ok outputs
  always_comb begin
    blocked = 1'b0;
    if (SD_CMD_VALID_IN) begin
      case (SD_CMD_IN)
        ewt_pkg::EWT_CMD_ACTV: blocked = !gap_ok || !act_ok[SD_BANK_IN];
        ewt_pkg::EWT_CMD_REF:  blocked = !gap_ok;
        ewt_pkg::EWT_CMD_MRS:  blocked = !gap_ok;
        ewt_pkg::EWT_CMD_PRE:  blocked = !pre_ok[SD_BANK_IN];
        default:               blocked = 1'b0;
      endcase
    end
  end

  // write one clears; a new misuse in the same cycle wins
  always_comb begin
    viol_d = viol_q;
    if (commit && PWRITE_IN && PADDR_IN == `EWT_OFF_STAT && PSTRB_IN[2]
        && PWDATA_IN[`EWT_ST_VIOL_BIT]) begin
      viol_d = 1'b0;
    end
    if (blocked) begin
      viol_d = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      viol_q <= 1'b0;
    end else begin
      viol_q <= viol_d;
    end
  end

  // ---------------------------------------------------------------
  // pc card access
  // ---------------------------------------------------------------
  assign pc_sel = PC_AREA_IN ? pc6_q : pc5_q;
  assign ted    = pc_sel[`EWT_TED_LSB +: 4];

  // card type is latched with the address; a start while busy is ignored
  always_comb begin
    io_card_d = io_card_q;
    if (PC_START_IN && !stb_busy) begin
      io_card_d = PC_A25_IN ? pc_sel[`EWT_SA_HI_BIT]
                            : pc_sel[`EWT_SA_LO_BIT];
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      io_card_q <= 1'b0;
    end else begin
      io_card_q <= io_card_d;
    end
  end

  ewt_pc_strobe u_stb (
    .clk_in   (CLOCK_IN),
    .rst_in   (RST_IN),
    .start_in (PC_START_IN),
    .end_in   (PC_END_IN),
    .write_in (PC_WRITE_IN),
    .ted_in   (ted),
    .rd_out   (PC_RD_ASSERT_OUT),
    .we_out   (PC_WE_ASSERT_OUT),
    .busy_out (stb_busy)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // all of these are flop outputs or slices of register flops
  assign PRDATA_OUT     = prdata_q;
  assign PREADY_OUT     = pready_q;
  assign PSLVERR_OUT    = pslverr_q;
  assign SD_ACTV_OK_OUT = act_ok;
  assign SD_PRE_OK_OUT  = pre_ok;
  assign SD_GAP_OK_OUT  = gap_ok;
  assign SD_TRP_OUT     = sdw_q[`EWT_TRP_LSB +: 2];
  assign SD_TRCD_OUT    = sdw_q[`EWT_TRCD_LSB +: 2];
  assign SD_CAS3_OUT    = sdw_q[`EWT_CAS_LSB +: 2];
  assign PC_IO_CARD_OUT = io_card_q;

endmodule // ewt_top

// ==== verification/ewt_assertions.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// port-level timing checks, bound into the top
// ------------------------------------------------------------
module ewt_assertions #(
  parameter int NUM_BANKS = 4
) (
  input wire logic                     CLOCK_IN,        // clock
  input wire logic                     RST_IN,          // reset
  input wire logic                     PSEL_IN,         // apb
  input wire logic                     PENABLE_IN,      // apb
  input wire logic                     PWRITE_IN,       // apb
  input wire logic [11:0]              PADDR_IN,        // apb
  input wire logic [31:0]              PWDATA_IN,       // apb
  input wire logic [31:0]              PRDATA_OUT,      // apb
  input wire logic                     PREADY_OUT,      // apb
  input wire logic                     PSLVERR_OUT,     // apb
  input wire logic                     SD_CMD_VALID_IN, // command strobe
  input wire ewt_pkg::ewt_sd_cmd_t     SD_CMD_IN,       // command
  input wire logic [$clog2(NUM_BANKS)-1:0] SD_BANK_IN,  // bank
  input wire logic                     SD_SELF_EXIT_IN, // self refresh out
  input wire logic                     SD_BANK_ACT_IN,  // bank-active mode
  input wire logic [NUM_BANKS-1:0]     SD_ACTV_OK_OUT,  // activate ok
  input wire logic [NUM_BANKS-1:0]     SD_PRE_OK_OUT,   // precharge ok
  input wire logic                     SD_GAP_OK_OUT    // gap elapsed
);
  logic [1:0] trwl_q; // shadow of the precharge start code

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  // shadow follows completed writes so hold checks know the wait
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      trwl_q <= 2'h0;
    end else if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == 12'h000) begin
      trwl_q <= PWDATA_IN[4:3];
    end
  end

  chk_ready_once: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("ready not a single pulse");
  chk_sdram_rsvd: assert property (
    PREADY_OUT && !PWRITE_IN && PADDR_IN == 12'h000 |-> (PRDATA_OUT & ~32'h00006D9B) == 32'h0)
    else $error("sdram reserved bits set");
  chk_card_rsvd: assert property (
    PREADY_OUT && !PWRITE_IN && PADDR_IN inside {12'h004, 12'h008}
    |-> PRDATA_OUT[31:22] == 10'h0 && PRDATA_OUT[19:15] == 5'h0) else $error("card reserved bits set");
  chk_bad_addr: assert property (PREADY_OUT && PADDR_IN > 12'h00C |-> PSLVERR_OUT && PRDATA_OUT == 32'h0)
    else $error("unmapped access not refused");
  chk_gap_ref: assert property (
    SD_CMD_VALID_IN && SD_CMD_IN == ewt_pkg::EWT_CMD_REF |=> !SD_GAP_OK_OUT [*2]) else $error("gap after refresh");
  chk_gap_self: assert property (SD_SELF_EXIT_IN |=> !SD_GAP_OK_OUT [*2])
    else $error("gap after self refresh exit");
  chk_actv_hold: assert property (
    SD_CMD_VALID_IN && SD_CMD_IN == ewt_pkg::EWT_CMD_WRITA && !SD_BANK_ACT_IN
    |=> SD_ACTV_OK_OUT[$past(SD_BANK_IN)] == (trwl_q == 2'h0)) else $error("activate hold wrong");
  chk_pre_hold: assert property (
    SD_CMD_VALID_IN && SD_CMD_IN == ewt_pkg::EWT_CMD_WRIT && SD_BANK_ACT_IN
    |=> SD_PRE_OK_OUT[$past(SD_BANK_IN)] == (trwl_q == 2'h0)) else $error("precharge hold wrong");

  cov_self_exit: cover property (SD_SELF_EXIT_IN);
  cov_refused: cover property (PSLVERR_OUT);
  cov_long_gap: cover property (!SD_GAP_OK_OUT [*8]);
endmodule // ewt_assertions

bind ewt_top ewt_assertions #(.NUM_BANKS(NUM_BANKS)) i_ewt_assertions (.*);

// ==== verification/ewt_card_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// card side: measures address to strobe in half cycles
// ------------------------------------------------------------
module ewt_card_model (
  input  wire logic clk_in,   // bus clock
  input  wire logic start_in, // address driven
  input  wire logic rd_in,    // read strobe
  input  wire logic we_in,    // write strobe
  output int        half_out  // measured half cycles
);
  logic run_q = 1'b0; // measuring
  int   cnt_q = 0;    // half cycles so far

  // both edges counted, so a half-cycle launch shows as an odd count
  always @(posedge clk_in or negedge clk_in) begin
    if (clk_in && start_in && !run_q) begin
      run_q <= 1'b1;
      cnt_q <= 0;
    end else if (run_q) begin
      cnt_q <= cnt_q + 1;
      if (rd_in || we_in) begin
        run_q    <= 1'b0;
        half_out <= cnt_q;
      end
    end
  end
endmodule // ewt_card_model

// ==== verification/test_ext_bus_wait_timing.sv ====
`timescale 1ns/1ps
`include "ewt_defs.svh"

module test_ext_bus_wait_timing;
  logic CLOCK_IN = 1'b0, RST_IN = 1'b1, PSEL_IN = 1'b0, PENABLE_IN = 1'b0, PWRITE_IN = 1'b0;
  logic [11:0] PADDR_IN = 12'h0;
  logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT;
  logic [3:0] PSTRB_IN = 4'hF, SD_ACTV_OK_OUT, SD_PRE_OK_OUT;
  logic SD_CMD_VALID_IN = 1'b0, SD_SELF_EXIT_IN = 1'b0, SD_BANK_ACT_IN = 1'b0, PC_START_IN = 1'b0;
  logic PC_AREA_IN = 1'b0, PC_A25_IN = 1'b0, PC_WRITE_IN = 1'b0, PC_END_IN = 1'b0;
  ewt_pkg::ewt_sd_cmd_t SD_CMD_IN = ewt_pkg::EWT_CMD_NOP;
  logic [1:0] SD_BANK_IN = 2'h0, SD_TRP_OUT, SD_TRCD_OUT, SD_CAS3_OUT;
  logic PREADY_OUT, PSLVERR_OUT, SD_GAP_OK_OUT, PC_IO_CARD_OUT, PC_RD_ASSERT_OUT, PC_WE_ASSERT_OUT;
  int err_count = 0, samples_checked = 0, cycles = 0, half;
  logic [31:0] seed = 32'h000056BF; // 22207
  logic [31:0] mdl[4] = '{32'h00000500, 32'h00000500, 32'h00000500, 32'h0};
  logic [31:0] msk[4] = '{`EWT_SDW_MASK, `EWT_PC_MASK, `EWT_PC_MASK, 32'h0};
  int gap_tab[4] = '{2, 3, 5, 8};

  ewt_top #(.NUM_BANKS(4)) i_ewt_top (.*);
  ewt_card_model i_ewt_card_model (.clk_in(CLOCK_IN), .start_in(PC_START_IN), .rd_in(PC_RD_ASSERT_OUT),
    .we_in(PC_WE_ASSERT_OUT), .half_out(half));

  // clock and a hang guard well above the expected run
  always #2 CLOCK_IN = ~CLOCK_IN;
  always @(posedge CLOCK_IN) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until ready is sampled high at a rising edge
  task automatic apb(input logic w, input int a, input logic [31:0] d, output logic [31:0] r);
    @(posedge CLOCK_IN);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN <= a[11:0];
    PWDATA_IN <= d;
    @(posedge CLOCK_IN);
    PENABLE_IN <= 1'b1;
    do @(posedge CLOCK_IN);
    while (PREADY_OUT !== 1'b1);
    r = PRDATA_OUT;
    chk("slverr", {31'h0, a > 12 || a % 4 != 0}, {31'h0, PSLVERR_OUT});
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
  endtask
  task automatic wr(input int a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
    if (a < 12 && a % 4 == 0) mdl[a[3:2]] = d & msk[a[3:2]];
  endtask
  task automatic rd(input int a);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk("rdata", (a < 13 && a % 4 == 0) ? mdl[a[3:2]] : 32'h0, r);
  endtask
  // m 0 watches the gap, 1 activate, 2 precharge; counts low cycles
  task automatic issue(input int m, input ewt_pkg::ewt_sd_cmd_t c, input logic [1:0] b, input int exp);
    int n;
    @(posedge CLOCK_IN);
    SD_BANK_ACT_IN <= m == 2;
    SD_CMD_VALID_IN <= c != ewt_pkg::EWT_CMD_NOP;
    SD_SELF_EXIT_IN <= c == ewt_pkg::EWT_CMD_NOP;
    SD_CMD_IN <= c;
    SD_BANK_IN <= b;
    @(posedge CLOCK_IN);
    SD_CMD_VALID_IN <= 1'b0;
    SD_SELF_EXIT_IN <= 1'b0;
    n = 0;
    do begin
      @(posedge CLOCK_IN);
      n++;
    end while (!(m == 0 ? SD_GAP_OK_OUT : m == 1 ? SD_ACTV_OK_OUT[b] : SD_PRE_OK_OUT[b]) && n < 20);
    chk("low_cycles", exp, n - 1);
  endtask
  task automatic pc(input logic ar, input logic hi, input logic [31:0] d, input logic w);
    int n;
    @(posedge CLOCK_IN);
    PC_START_IN <= 1'b1;
    PC_AREA_IN <= ar;
    PC_A25_IN <= hi;
    PC_WRITE_IN <= w;
    @(posedge CLOCK_IN);
    PC_START_IN <= 1'b0;
    n = 0;
    while (PC_RD_ASSERT_OUT !== 1'b1 && PC_WE_ASSERT_OUT !== 1'b1 && n < 20) begin
      @(posedge CLOCK_IN);
      n++;
    end
    @(posedge CLOCK_IN);
    chk("io_card", {31'h0, hi ? d[21] : d[20]}, {31'h0, PC_IO_CARD_OUT});
    chk("delay", 2 * d[14:11] + 1, half);
    chk("strobes", {30'h0, w, !w}, {30'h0, PC_WE_ASSERT_OUT, PC_RD_ASSERT_OUT});
    PC_END_IN <= 1'b1;
    @(posedge CLOCK_IN);
    PC_END_IN <= 1'b0;
    @(posedge CLOCK_IN);
    chk("strobes_off", 32'h0, {30'h0, PC_WE_ASSERT_OUT, PC_RD_ASSERT_OUT});
  endtask
  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    repeat (8) @(posedge CLOCK_IN);
    RST_IN <= 1'b0;
    for (int i = 0; i < 5; i++) rd(4 * i);
    wr(2, 32'hFFFFFFFF);
    wr(0, 32'hFFFFFFFF);
    rd(0);
    for (int i = 1; i < 3; i++) begin
      wr(4 * i, rnd());
      rd(4 * i);
    end
    // each wait code against every command or self refresh release that starts it
    for (int c = 0; c < 4; c++) begin
      d = rnd();
      d[1:0] = c[1:0];
      d[4:3] = c[1:0];
      wr(0, d);
      rd(0);
      chk("shared", {26'h0, mdl[0][14:13], mdl[0][11:10], mdl[0][8:7]}, {26'h0, SD_TRP_OUT, SD_TRCD_OUT, SD_CAS3_OUT});
      issue(0, ewt_pkg::EWT_CMD_REF, d[31:30], gap_tab[c]);
      issue(0, ewt_pkg::EWT_CMD_NOP, d[31:30], gap_tab[c]);
      issue(1, ewt_pkg::EWT_CMD_WRITA, d[31:30], c);
      issue(2, ewt_pkg::EWT_CMD_WRIT, d[31:30], c);
    end
    // mode set inside the gap sets the sticky flag
    SD_CMD_VALID_IN <= 1'b1;
    SD_CMD_IN <= ewt_pkg::EWT_CMD_REF;
    @(posedge CLOCK_IN) SD_CMD_IN <= ewt_pkg::EWT_CMD_MRS;
    @(posedge CLOCK_IN) SD_CMD_VALID_IN <= 1'b0;
    issue(0, ewt_pkg::EWT_CMD_NOP, 2'h0, 8);
    mdl[3] = 32'h00010000;
    rd(12);
    wr(12, 32'h00010000);
    mdl[3] = 32'h0;
    rd(12);
    // both areas, both top-address levels, both directions
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      wr(4 + 4 * i[0], d);
      pc(i[0], i[1], d, i[2]);
    end
    tally_and_finish();
  end
endmodule // test_ext_bus_wait_timing
